/* hw/sim_regs.svh */
// register map, field positions and reset values of the interrupt mask stage
// assumes a 32-bit register bus with byte addresses in the low address bits
`ifndef SIM_REGS_SVH
`define SIM_REGS_SVH

// ==========================================================
// widths
`define SIM_ADDR_W 12
`define SIM_DATA_W 32
`define SIM_NUM_EVT 7

// ==========================================================
// byte offsets
`define SIM_OFS_RAW 12'h050
`define SIM_OFS_MASK 12'h054
`define SIM_OFS_MISC 12'h058
`define SIM_OFS_BORCTL 12'h060

// ==========================================================
// event bit positions, shared by raw, mask and masked registers
`define SIM_BIT_PLL_LOCK 6
`define SIM_BIT_CUR_LIM 5
`define SIM_BIT_INT_OSC 4
`define SIM_BIT_MAIN_OSC 3
`define SIM_BIT_REG_UNREG 2
`define SIM_BIT_BROWNOUT 1
`define SIM_BIT_PLL_FAULT 0
// brown-out reset-instead-of-interrupt select in the brown-out control register
`define SIM_BIT_BOR_SEL 1

// ==========================================================
// reset values and bus answers
`define SIM_MASK_RST 7'h00
`define SIM_RAW_RST 7'h00
`define SIM_BOR_SEL_RST 1'h0
`define SIM_RESP_OKAY 2'h0
`define SIM_RESP_DECERR 2'h3

`endif

/* hw/sim_pkg.sv */
// types shared by the interrupt mask stage modules
// assumes the register header is included by each user
`default_nettype none

package sim_pkg;

    // ==========================================================
    // one bit per system-control event
    typedef logic [6:0] sim_evt_t;

    // register selected by a bus address
    typedef enum logic [2:0] {
        SIM_SEL_RAW,
        SIM_SEL_MASK,
        SIM_SEL_MISC,
        SIM_SEL_BORCTL,
        SIM_SEL_NONE
    } sim_sel_e;

endpackage

`default_nettype wire

/* hw/sim_rst_sync.sv */
// reset release synchroniser
// assumes an active-low asynchronous reset input on the block clock
`timescale 1ns/1ps
`default_nettype none

module sim_rst_sync (
    input wire logic i_clk,
    input wire logic i_rst_n,
    output logic o_rst_n
);

    // ==========================================================
    // two-stage release
    logic meta_q; // first stage, read only by the second
    logic sync_q; // second stage

    // assert at once, release after two edges
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            sync_q <= meta_q;
        end
    end

    assign o_rst_n = sync_q;

endmodule

`default_nettype wire

/* hw/sim_evt_latch.sv */
// sticky event latches, set by hardware, cleared by a one-cycle clear vector
// assumes set and clear are synchronous to the clock
`timescale 1ns/1ps
`default_nettype none

module sim_evt_latch #(
    parameter int W = 7
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    output logic [W-1:0] o_stat
);

    // ==========================================================
    // one latch per event
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic stat_q; // sticky status bit
            // a set in the clear cycle wins so no event is lost
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    stat_q <= 1'b0;
                end else if (i_set[g]) begin
                    stat_q <= 1'b1;
                end else if (i_clr[g]) begin
                    stat_q <= 1'b0;
                end
            end
            assign o_stat[g] = stat_q;
        end
    endgenerate

endmodule

`default_nettype wire

/* hw/sim_top.sv */
// system-control interrupt mask stage with an AXI4-Lite register slave
// assumes event inputs are synchronous to I_CLK and high while a condition is seen
//
// How it works
// - mask bit 6 gates PLL lock event
// - mask bit 5 gates current limit event
// - mask bit 4 gates internal oscillator fault
// - mask bit 3 gates main oscillator fault
// - mask bit 2 gates regulator unregulated event
// - mask bit 1 gates brown-out event
// - mask bit 0 gates PLL fault event
// - mask at 0x054, read-write, resets zero
// - bits 31:7 reserved, software leaves them alone
// - raw status set only by hardware events, cleared through the masked register
// - masked status is raw AND mask, brown-out bit also gated by the reset select
// - write one clears masked and raw bit
// - brown-out interrupts only when reset select clear
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sim_regs.svh"

module sim_top
    import sim_pkg::*;
#(
    parameter int ADDR_W = `SIM_ADDR_W
) (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    // write address channel
    input wire logic [ADDR_W-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    // write data channel
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    // write response channel
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    // read address channel
    input wire logic [ADDR_W-1:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    // read data channel
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // hardware event detectors
    input wire logic I_PLL_LOCK_EVT,
    input wire logic I_CUR_LIM_EVT,
    input wire logic I_INT_OSC_FAULT_EVT,
    input wire logic I_MAIN_OSC_FAULT_EVT,
    input wire logic I_REG_UNREG_EVT,
    input wire logic I_BROWNOUT_EVT,
    input wire logic I_PLL_FAULT_EVT,
    // to the processor interrupt controller
    output logic O_IRQ,
    output logic [6:0] O_MASKED_STATUS,
    // brown-out reset request when reset is selected over interrupt
    output logic O_BROWNOUT_RESET_REQ
);

    // ==========================================================
    // address decode
    // ==========================================================

    // maps a byte address onto a register, used by both paths
    function automatic sim_sel_e decode(input logic [ADDR_W-1:0] a);
        sim_sel_e s;
        s = SIM_SEL_NONE;
        if (a == ADDR_W'(`SIM_OFS_RAW)) begin
            s = SIM_SEL_RAW;
        end else if (a == ADDR_W'(`SIM_OFS_MASK)) begin
            s = SIM_SEL_MASK;
        end else if (a == ADDR_W'(`SIM_OFS_MISC)) begin
            s = SIM_SEL_MISC;
        end else if (a == ADDR_W'(`SIM_OFS_BORCTL)) begin
            s = SIM_SEL_BORCTL;
        end
        return s;
    endfunction

    // ==========================================================
    // reset
    // ==========================================================

    logic rst_n; // released copy of I_RSTN

    sim_rst_sync u_rst (
        .i_clk(I_CLK),
        .i_rst_n(I_RSTN),
        .o_rst_n(rst_n)
    );

    // ==========================================================
    // write channel
    // ==========================================================

    logic awready_q; // address slot free
    logic wready_q; // data slot free
    logic aw_held_q; // address taken, waiting for data
    logic w_held_q; // data taken, waiting for address
    logic [ADDR_W-1:0] awaddr_q; // held write address
    logic [31:0] wdata_q; // held write data
    logic [3:0] wstrb_q; // held byte enables
    logic bvalid_q; // response pending
    logic [1:0] bresp_q; // response code
    logic wr_go; // both halves present, write this cycle
    sim_sel_e wr_sel; // register hit by the write
    logic wr_lane0; // low byte lane enabled

    assign wr_go = aw_held_q && w_held_q && !bvalid_q;
    assign wr_sel = decode(awaddr_q);
    assign wr_lane0 = wstrb_q[0];

    // take the address independently of the data
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b0;
            awaddr_q <= '0;
        end else if (I_AWVALID && awready_q) begin
            // address accepted, close the slot
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
            awaddr_q <= I_AWADDR;
        end else if (wr_go) begin
            // write done, slot opens after the response
            aw_held_q <= 1'b0;
        end else begin
            // open while nothing is held and no response waits
            awready_q <= !aw_held_q && !bvalid_q;
        end
    end

    // take the data independently of the address
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (I_WVALID && wready_q) begin
            // data accepted, close the slot
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
            wdata_q <= I_WDATA;
            wstrb_q <= I_WSTRB;
        end else if (wr_go) begin
            w_held_q <= 1'b0;
        end else begin
            wready_q <= !w_held_q && !bvalid_q;
        end
    end

    // response after both halves are in
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= `SIM_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            // unmapped addresses answer with a decode error
            bresp_q <= (wr_sel == SIM_SEL_NONE) ? `SIM_RESP_DECERR : `SIM_RESP_OKAY;
        end else if (bvalid_q && I_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // ==========================================================
    // software registers
    // ==========================================================

    sim_evt_t mask_q; // interrupt_mask_control
    logic bor_sel_q; // brownout_reset_select

    // mask register, only bits 6:0 store, upper bits are dropped
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= `SIM_MASK_RST; // every interrupt starts disabled
        end else if (wr_go && wr_lane0 && wr_sel == SIM_SEL_MASK) begin
            mask_q <= wdata_q[`SIM_NUM_EVT-1:0];
        end
    end

    // brown-out control register, reset-instead-of-interrupt select
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            bor_sel_q <= `SIM_BOR_SEL_RST;
        end else if (wr_go && wr_lane0 && wr_sel == SIM_SEL_BORCTL) begin
            bor_sel_q <= wdata_q[`SIM_BIT_BOR_SEL];
        end
    end

    // ==========================================================
    // raw event status
    // ==========================================================

    sim_evt_t evt_set; // hardware set vector
    sim_evt_t evt_clr; // one-cycle clear from a masked-status write
    sim_evt_t raw; // raw_event_status

    // gather the detectors into the shared bit layout
    always_comb begin
        evt_set = `SIM_RAW_RST;
        evt_set[`SIM_BIT_PLL_LOCK] = I_PLL_LOCK_EVT;
        evt_set[`SIM_BIT_CUR_LIM] = I_CUR_LIM_EVT;
        evt_set[`SIM_BIT_INT_OSC] = I_INT_OSC_FAULT_EVT;
        evt_set[`SIM_BIT_MAIN_OSC] = I_MAIN_OSC_FAULT_EVT;
        evt_set[`SIM_BIT_REG_UNREG] = I_REG_UNREG_EVT;
        evt_set[`SIM_BIT_BROWNOUT] = I_BROWNOUT_EVT;
        evt_set[`SIM_BIT_PLL_FAULT] = I_PLL_FAULT_EVT;
    end

    // write one to the masked register clears the raw bit; zero does nothing
    // a write to the raw register itself never reaches the latches
    always_comb begin
        if (wr_go && wr_lane0 && wr_sel == SIM_SEL_MISC) begin
            evt_clr = wdata_q[`SIM_NUM_EVT-1:0];
        end else begin
            evt_clr = '0;
        end
    end

    // sticky latches, event set beats a clear in the same cycle
    sim_evt_latch #(
        .W(`SIM_NUM_EVT)
    ) u_raw (
        .i_clk(I_CLK),
        .i_rst_n(rst_n),
        .i_set(evt_set),
        .i_clr(evt_clr),
        .o_stat(raw)
    );

    // ==========================================================
    // masking
    // ==========================================================

    sim_evt_t gate; // effective per-event enable
    sim_evt_t masked; // masked status seen by software and the controller

    // per-event enables; brown-out also needs the reset select clear
    always_comb begin
        gate = '0;
        gate[`SIM_BIT_PLL_LOCK] = mask_q[`SIM_BIT_PLL_LOCK];
        gate[`SIM_BIT_CUR_LIM] = mask_q[`SIM_BIT_CUR_LIM];
        gate[`SIM_BIT_INT_OSC] = mask_q[`SIM_BIT_INT_OSC];
        gate[`SIM_BIT_MAIN_OSC] = mask_q[`SIM_BIT_MAIN_OSC];
        gate[`SIM_BIT_REG_UNREG] = mask_q[`SIM_BIT_REG_UNREG];
        gate[`SIM_BIT_BROWNOUT] = mask_q[`SIM_BIT_BROWNOUT] && !bor_sel_q;
        gate[`SIM_BIT_PLL_FAULT] = mask_q[`SIM_BIT_PLL_FAULT];
    end

    // clearing raw clears masked too, since masked follows raw
    assign masked = raw & gate;

    // ==========================================================
    // interrupt outputs
    // ==========================================================

    logic irq_q; // processor interrupt line
    sim_evt_t masked_q; // registered copy for the controller
    logic bor_rst_q; // brown-out reset request

    // one line, high while any masked bit is set, refreshed every cycle
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            masked_q <= `SIM_RAW_RST;
        end else begin
            irq_q <= |masked;
            masked_q <= masked;
        end
    end

    // brown-out turns into a reset request when reset is selected
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            bor_rst_q <= 1'b0;
        end else begin
            bor_rst_q <= raw[`SIM_BIT_BROWNOUT] && bor_sel_q;
        end
    end

    // ==========================================================
    // read channel
    // ==========================================================

    logic arready_q; // read address slot free
    logic rvalid_q; // read data pending
    logic [31:0] rdata_q; // read data
    logic [1:0] rresp_q; // read response code
    sim_sel_e rd_sel; // register hit by the read
    logic [31:0] rd_word; // word for the selected register

    assign rd_sel = decode(I_ARADDR);

    // reserved bits 31:7 read as zero
    always_comb begin
        rd_word = '0;
        unique case (rd_sel)
            SIM_SEL_RAW: begin
                rd_word[`SIM_NUM_EVT-1:0] = raw;
            end
            SIM_SEL_MASK: begin
                rd_word[`SIM_NUM_EVT-1:0] = mask_q;
            end
            SIM_SEL_MISC: begin
                rd_word[`SIM_NUM_EVT-1:0] = masked;
            end
            SIM_SEL_BORCTL: begin
                rd_word[`SIM_BIT_BOR_SEL] = bor_sel_q;
            end
            SIM_SEL_NONE: begin
                rd_word = '0;
            end
        endcase
    end

    // one read at a time, data one edge after the address is taken
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `SIM_RESP_OKAY;
        end else if (I_ARVALID && arready_q) begin
            // capture the word and close the slot
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= (rd_sel == SIM_SEL_NONE) ? `SIM_RESP_DECERR : `SIM_RESP_OKAY;
        end else if (rvalid_q && I_RREADY) begin
            rvalid_q <= 1'b0;
        end else begin
            // reopen once the data has gone
            arready_q <= !rvalid_q;
        end
    end

    // ==========================================================
    // port drive, all from flip-flops
    // ==========================================================

    assign O_AWREADY = awready_q;
    assign O_WREADY = wready_q;
    assign O_BVALID = bvalid_q;
    assign O_BRESP = bresp_q;
    assign O_ARREADY = arready_q;
    assign O_RVALID = rvalid_q;
    assign O_RDATA = rdata_q;
    assign O_RRESP = rresp_q;
    assign O_IRQ = irq_q;
    assign O_MASKED_STATUS = masked_q;
    assign O_BROWNOUT_RESET_REQ = bor_rst_q;

endmodule

`default_nettype wire

/* verification/sim_intc_model.sv */
// interrupt controller model: counts request edges on the level line
// assumes the line is synchronous to the clock and active high
`timescale 1ns/1ps
`default_nettype none

module sim_intc_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_irq,
    output int o_edges
);
    // ==========================================================
    // edge detector
    logic irq_q; // line as seen one cycle ago

    // a request is taken on each rising edge of the line
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_q <= 1'h0;
            o_edges <= 0;
        end else begin
            irq_q <= i_irq;
            if (i_irq && !irq_q) begin
                o_edges <= o_edges + 1;
            end
        end
    end
endmodule

`default_nettype wire

/* verification/sim_chk.sv */
// port checks for the interrupt mask stage
// assumes one clock domain and the register map of the shared header
`timescale 1ns/1ps
`default_nettype none
`include "sim_regs.svh"

module sim_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic [ADDR_W-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    input wire logic O_AWREADY,
    input wire logic I_WVALID,
    input wire logic O_WREADY,
    input wire logic [1:0] O_BRESP,
    input wire logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic I_ARVALID,
    input wire logic O_ARREADY,
    input wire logic [31:0] O_RDATA,
    input wire logic [1:0] O_RRESP,
    input wire logic O_RVALID,
    input wire logic I_RREADY,
    input wire logic O_IRQ,
    input wire logic [6:0] O_MASKED_STATUS,
    input wire logic O_BROWNOUT_RESET_REQ
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);

    // ==========================================================
    // helper terms
    logic wr_both; // address and data taken at one edge
    logic unmapped; // write address outside the map
    assign wr_both = I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
    assign unmapped = !(I_AWADDR inside {`SIM_OFS_RAW, `SIM_OFS_MASK,
        `SIM_OFS_MISC, `SIM_OFS_BORCTL});

    // ==========================================================
    // interrupt line and masked bits
    chk_irq_is_or: assert property (O_IRQ == |O_MASKED_STATUS)
        else $error("irq differs from or of masked bits");
    chk_bor_no_irq: assert property (!(O_BROWNOUT_RESET_REQ && O_MASKED_STATUS[1]))
        else $error("brown-out gives reset and interrupt at once");
    chk_irq_drop_write: assert property ($fell(O_IRQ) |-> $past(O_BVALID))
        else $error("irq dropped without a register write");

    // ==========================================================
    // register bus answers
    chk_wr_answer: assert property (wr_both && !unmapped |->
        ##2 O_BVALID && O_BRESP == `SIM_RESP_OKAY)
        else $error("write answer late or not okay");
    chk_wr_decerr: assert property (wr_both && unmapped |->
        ##2 O_BVALID && O_BRESP == `SIM_RESP_DECERR)
        else $error("unmapped write not refused");
    chk_b_hold: assert property (O_BVALID && !I_BREADY |=>
        O_BVALID && $stable(O_BRESP))
        else $error("write response not held");
    chk_r_hold: assert property (O_RVALID && !I_RREADY |=>
        O_RVALID && $stable(O_RDATA) && $stable(O_RRESP))
        else $error("read response not held");
    chk_rd_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("read answer late");
    chk_rd_reserved: assert property (O_RVALID |-> O_RDATA[31:7] == '0)
        else $error("reserved read bits not zero");

    // main scenarios
    cov_irq: cover property ($rose(O_IRQ));
    cov_bor_req: cover property ($rose(O_BROWNOUT_RESET_REQ));
    cov_decerr: cover property (wr_both && unmapped);
endmodule

bind sim_top sim_chk #(.ADDR_W(ADDR_W)) sim_chk_inst (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
    .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID),
    .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
    .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP),
    .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_IRQ(O_IRQ),
    .O_MASKED_STATUS(O_MASKED_STATUS), .O_BROWNOUT_RESET_REQ(O_BROWNOUT_RESET_REQ));

`default_nettype wire

/* verification/sim_top_bench.sv */
// testbench: bus master, event driver and integer model of the mask stage
// assumes the design, checker and controller model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "sim_regs.svh"

module sim_top_bench;
    import sim_pkg::*;
    localparam logic [1:0] OK = `SIM_RESP_OKAY;
    localparam logic [1:0] DE = `SIM_RESP_DECERR;

    // ==========================================================
    // stimulus, outputs and model state
    logic clk = '0;
    logic rst_n = '0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic [6:0] ev = '0; // event inputs, bit order of the raw register
    logic awready, wready, bvalid, arready, rvalid, irq, borq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [6:0] mstat;
    int miscompares = 0, cmp_count = 0, edges, raw_m = 0, mask_m = 0, sel_m = 0, v;

    sim_top sim_top_inst (.I_CLK(clk), .I_RSTN(rst_n), .I_AWADDR(awaddr),
        .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
        .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
        .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
        .I_PLL_LOCK_EVT(ev[6]), .I_CUR_LIM_EVT(ev[5]), .I_INT_OSC_FAULT_EVT(ev[4]),
        .I_MAIN_OSC_FAULT_EVT(ev[3]), .I_REG_UNREG_EVT(ev[2]), .I_BROWNOUT_EVT(ev[1]),
        .I_PLL_FAULT_EVT(ev[0]), .O_IRQ(irq), .O_MASKED_STATUS(mstat),
        .O_BROWNOUT_RESET_REQ(borq));
    sim_intc_model sim_intc_model_inst (.i_clk(clk), .i_rst_n(rst_n), .i_irq(irq),
        .o_edges(edges));

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // compare, bus and event tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // one write; address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk("bresp", bresp, er);
    endtask

    // one read, compared with the model value
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rready <= 1'h0;
        chk("rdata", rdata, ed);
        chk("rresp", rresp, er);
    endtask

    // one-cycle event pulse; the model latches it
    task automatic pulse(input logic [6:0] p);
        @(posedge clk);
        ev <= p;
        @(posedge clk);
        ev <= '0;
        raw_m |= p;
    endtask

    // let the masked outputs follow, then compare them with the model
    task automatic chk_out();
        int m;
        repeat (2) @(posedge clk);
        #1;
        m = raw_m & mask_m & ~(sel_m << 1);
        chk("masked", mstat, m);
        chk("irq", irq, m != 0);
        chk("bor_req", borq, raw_m[1] & sel_m);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // watchdog: well beyond the less than one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("watchdog expired");
        complete_run();
    end

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'h2BC8A05A));
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        repeat (6) @(posedge clk);
        // reset values of every register
        rd(`SIM_OFS_MASK, '0, OK);
        rd(`SIM_OFS_RAW, '0, OK);
        rd(`SIM_OFS_MISC, '0, OK);
        rd(`SIM_OFS_BORCTL, '0, OK);
        chk_out();
        $display("test reset values done");
        // access kinds, ignored writes and an unmapped place
        wr(`SIM_OFS_MASK, 32'h7F, 4'hF, OK);
        rd(`SIM_OFS_MASK, 32'h7F, OK);
        wr(`SIM_OFS_MASK, '0, 4'h0, OK);
        rd(`SIM_OFS_MASK, 32'h7F, OK);
        wr(`SIM_OFS_MASK, '0, 4'hF, OK);
        wr(`SIM_OFS_RAW, 32'h7F, 4'hF, OK);
        rd(`SIM_OFS_RAW, '0, OK);
        wr(12'h100, 32'h7F, 4'hF, DE);
        rd(12'h100, '0, DE);
        chk_out();
        $display("test register access done");
        // each mask alone, with a neighbouring event left masked off
        for (int b = 0; b < 7; b++) begin
            mask_m = 1 << b;
            wr(`SIM_OFS_MASK, mask_m, 4'hF, OK);
            pulse(7'(mask_m | (1 << ((b + 1) % 7))));
            chk_out();
            rd(`SIM_OFS_RAW, raw_m, OK);
            wr(`SIM_OFS_MISC, raw_m, 4'hF, OK);
            raw_m = 0;
            chk_out();
            chk("irq_edges", edges, b + 1);
        end
        $display("test single masks done");
        // random masks, events, select and clears; reserved bits always written 0
        for (int i = 0; i < 24; i++) begin
            mask_m = $urandom & 32'h7F;
            sel_m = $urandom & 1;
            wr(`SIM_OFS_MASK, mask_m, 4'hF, OK);
            wr(`SIM_OFS_BORCTL, sel_m << 1, 4'hF, OK);
            pulse(7'($urandom));
            chk_out();
            rd(`SIM_OFS_MISC, raw_m & mask_m & ~(sel_m << 1), OK);
            v = $urandom & 32'h7F;
            wr(`SIM_OFS_MISC, v, 4'hF, OK);
            raw_m &= ~v;
            rd(`SIM_OFS_RAW, raw_m, OK);
            chk_out();
        end
        $display("test random traffic done");
        complete_run();
    end
endmodule

`default_nettype wire
